// [hw/hbridge_pkg.sv]
// Constants and types shared by the H-bridge serial register bank
package hbridge_pkg;

    // Command word layout
    localparam int CMD_WRITE_BIT = 15;
    localparam int CMD_SEL_HI = 14;
    localparam int CMD_SEL_LO = 13;
    localparam int FRAME_BITS = 16;

    // Register select codes
    localparam logic [1:0] SEL_IDENTITY = 2'h0;
    localparam logic [1:0] SEL_FAULT_FLAGS = 2'h1;
    localparam logic [1:0] SEL_FAULT_MASK = 2'h2;
    localparam logic [1:0] SEL_DRIVE_CONFIG = 2'h3;

    // Fault flag positions
    localparam int FLG_FRAMING = 11;
    localparam int FLG_PUMP_LOW = 10;
    localparam int FLG_SUPPLY_LOW = 9;
    localparam int FLG_SUPPLY_HIGH = 8;
    localparam int FLG_THERMAL_WARN = 1;
    localparam int FLG_OVERTEMP = 0;
    localparam int NUM_FLAGS = 12;
    localparam int NUM_DETECTORS = 11;

    // Mask and configuration field positions
    localparam int MSK_OV_PROTECT_OFF = 12;
    localparam int CFG_OPEN_LOAD_CHECK = 12;
    localparam int CFG_THERMAL_DERATE = 11;
    localparam int CFG_ACTIVE_LIMIT = 10;
    localparam int CFG_LIMIT_HI = 9;
    localparam int CFG_LIMIT_LO = 8;
    localparam int CFG_SLEW_HI = 7;
    localparam int CFG_SLEW_LO = 5;
    localparam int CFG_OUTPUT_ENABLE = 4;
    localparam int CFG_HBRIDGE = 3;
    localparam int CFG_DRIVE_SOURCE = 2;
    localparam int CFG_VIRTUAL_2 = 1;
    localparam int CFG_VIRTUAL_1 = 0;
    localparam int REG_BITS = 13;

    // Reset values
    localparam logic [12:0] MASK_RESET = 13'h06F1;
    localparam logic [12:0] CONFIG_RESET = 13'h0D98;
    localparam logic [11:0] FLAGS_RESET = 12'h000;

    // Synchronised pin samples
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
        logic dis;
        logic wake_enable_pin;
        logic in1;
        logic in2;
        logic [10:0] fault;
    } pin_sample_t;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_SHIFT = 2'b01,
        LK_END = 2'b11
    } link_state_t;

    // Controls handed to the power stage
    typedef struct packed {
        logic outputs_on;
        logic drive_1;
        logic drive_2;
        logic limit_active;
        logic [1:0] limit_code;
        logic limit_half;
        logic limit_blanked;
        logic [2:0] slew_code;
        logic open_load_check;
        logic open_load_test;
        logic ov_protect;
    } drive_ctl_t;

endpackage : hbridge_pkg

// [hw/hbridge_spi_fault_registers.sv]
// Serial slave register bank with latched fault reporting for an H-bridge driver
//
// Operation
// - Faults latch on detection, stay until cleared
// - Clear only non-active faults on a clear event
// - Disable pin falling edge clears non-active faults
// - Enable pin rising edge clears non-active faults
// - Writing ones to fault flags clears them
// - Zero or non-16-multiple clock count flags framing
// - Write to identity register flags framing error
// - Command bit 15 selects write or read
// - Bits 14:13 select the target register
// - Identity reads zeros, identifier, revision bits
// - Fault flag bit positions fixed as mapped
// - Flags read zero, upper nibble echoes select
// - Masked latched fault drives fault pin low
// - Mask bit 12 downgrades overvoltage to warning
// - Mask resets to pump, supply low, shorts, overtemp
// - Drive configuration has documented reset value
// - Open-load check bit arms and triggers test; the trigger needs outputs off
// - Thermal derate selects blanking or half limit
// - Output enable gated by enable and disable pins
// - Drive source picks virtual bits or pins
// - Half-bridge disables limit, open-load, overvoltage action
// - Framing error discards the whole transfer
module hbridge_spi_fault_registers
    import hbridge_pkg::*;
#(
    parameter logic DEVICE_ID_BIT = 1'b0,     // Arbitrary value
    parameter logic [3:0] REVISION = 4'h0     // Arbitrary value
)
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    // Serial port
    input wire logic SCLK_IN,
    input wire logic CS_N_IN,
    input wire logic MOSI_IN,
    output logic MISO_OUT,
    output logic MISO_OE_N_OUT,
    // Control pins
    input wire logic OUTPUT_DISABLE_PIN_IN,
    input wire logic WAKE_ENABLE_PIN_IN,
    input wire logic DRIVE_1_PIN_IN,
    input wire logic DRIVE_2_PIN_IN,
    // Fault detectors, bit order as the flag register bits 10..0
    input wire logic [10:0] FAULT_ACTIVE_IN,
    // Fault pin and power stage controls
    output logic FAULT_PIN_N_OUT,
    output drive_ctl_t DRIVE_CTL_OUT
);

    typedef struct packed {
        pin_sample_t s1;
        pin_sample_t s2;
        logic sclk_d;
        logic cs_n_d;
        logic dis_d;
        logic wake_enable_pin_d;
        link_state_t lk;
        logic [15:0] shift;
        logic [3:0] cnt;
        logic any;
        logic miso;
        logic miso_oe_n;
        logic [1:0] sel;
        logic [11:0] flags;
        logic [12:0] mask;
        logic [12:0] cfg;
        logic fault_n;
        drive_ctl_t ctl;
    } core_state_t;

    // Synchronisers start at the pins' idle levels so no false frame follows reset
    localparam pin_sample_t PINS_IDLE = '{
        sclk: 1'b0,
        cs_n: 1'b1,
        mosi: 1'b0,
        dis: 1'b0,
        wake_enable_pin: 1'b0,
        in1: 1'b0,
        in2: 1'b0,
        fault: 11'h000
    };

    localparam core_state_t CORE_RESET = '{
        s1: PINS_IDLE,
        s2: PINS_IDLE,
        sclk_d: 1'b0,
        cs_n_d: 1'b1,
        dis_d: 1'b0,
        wake_enable_pin_d: 1'b0,
        lk: LK_IDLE,
        shift: 16'h0000,
        cnt: 4'h0,
        any: 1'b0,
        miso: 1'b0,
        miso_oe_n: 1'b1,
        sel: SEL_FAULT_FLAGS,
        flags: FLAGS_RESET,
        mask: MASK_RESET,
        cfg: CONFIG_RESET,
        fault_n: 1'b1,
        ctl: '0
    };

    core_state_t s_reg;
    core_state_t s_next;
    pin_sample_t pins;
    logic [15:0] readback;
    logic [11:0] active;
    logic [11:0] clr_mask;
    logic [11:0] set_mask;
    logic frame_bad;
    logic frame_ok;
    logic is_write;
    logic [1:0] cmd_sel;
    logic clr_event;
    logic half;

    assign pins = '{
        sclk: SCLK_IN,
        cs_n: CS_N_IN,
        mosi: MOSI_IN,
        dis: OUTPUT_DISABLE_PIN_IN,
        wake_enable_pin: WAKE_ENABLE_PIN_IN,
        in1: DRIVE_1_PIN_IN,
        in2: DRIVE_2_PIN_IN,
        fault: FAULT_ACTIVE_IN
    };

    // Word returned for the register selected by the previous frame
    always_comb
    begin
        case (s_reg.sel)
            SEL_IDENTITY: readback = {11'h000, DEVICE_ID_BIT, REVISION};
            SEL_FAULT_FLAGS: readback = {1'b0, SEL_FAULT_FLAGS, 1'b0, s_reg.flags};
            SEL_FAULT_MASK: readback = {1'b0, SEL_FAULT_MASK, s_reg.mask};
            default: readback = {1'b0, SEL_DRIVE_CONFIG, s_reg.cfg};
        endcase
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.s1 = pins;
        s_next.s2 = s_reg.s1;
        s_next.sclk_d = s_reg.s2.sclk;
        s_next.cs_n_d = s_reg.s2.cs_n;
        s_next.dis_d = s_reg.s2.dis;
        s_next.wake_enable_pin_d = s_reg.s2.wake_enable_pin;

        is_write = s_reg.shift[CMD_WRITE_BIT];
        cmd_sel = s_reg.shift[CMD_SEL_HI:CMD_SEL_LO];
        // Clock count must be nonzero and a whole number of words
        frame_bad = (s_reg.lk == LK_END) && (!s_reg.any || s_reg.cnt != 4'h0
            || (is_write && cmd_sel == SEL_IDENTITY));
        frame_ok = (s_reg.lk == LK_END) && !frame_bad;

        case (s_reg.lk)
            LK_IDLE:
            begin
                if (s_reg.cs_n_d && !s_reg.s2.cs_n)
                begin
                    s_next.shift = readback;
                    s_next.miso = readback[15];
                    s_next.miso_oe_n = 1'b0;
                    s_next.cnt = 4'h0;
                    s_next.any = 1'b0;
                    s_next.lk = LK_SHIFT;
                end
            end
            LK_SHIFT:
            begin
                if (s_reg.s2.cs_n)
                begin
                    s_next.miso_oe_n = 1'b1;
                    s_next.lk = LK_END;
                end
                else if (s_reg.sclk_d && !s_reg.s2.sclk)
                begin
                    // Sample on falling edge; excess bits shift through for daisy chains
                    s_next.shift = {s_reg.shift[14:0], s_reg.s2.mosi};
                    s_next.cnt = s_reg.cnt + 4'h1;
                    s_next.any = 1'b1;
                end
                else if (!s_reg.sclk_d && s_reg.s2.sclk)
                begin
                    s_next.miso = s_reg.shift[15];
                end
            end
            LK_END:
            begin
                s_next.lk = LK_IDLE;
                if (frame_ok)
                begin
                    s_next.sel = cmd_sel;
                    if (is_write && cmd_sel == SEL_FAULT_MASK)
                    begin
                        s_next.mask = s_reg.shift[REG_BITS-1:0];
                    end
                    if (is_write && cmd_sel == SEL_DRIVE_CONFIG)
                    begin
                        s_next.cfg = s_reg.shift[REG_BITS-1:0];
                    end
                end
            end
            default:
            begin
                s_next.lk = LK_IDLE;
                s_next.miso_oe_n = 1'b1;
            end
        endcase

        // Fault latching; a detector set always wins over a clear
        active = {1'b0, s_reg.s2.fault};
        clr_event = (s_reg.dis_d && !s_reg.s2.dis)
            || (!s_reg.wake_enable_pin_d && s_reg.s2.wake_enable_pin);
        clr_mask = 12'h000;
        if (clr_event)
        begin
            clr_mask = 12'hFFF;
        end
        else if (frame_ok && is_write && cmd_sel == SEL_FAULT_FLAGS)
        begin
            clr_mask = s_reg.shift[NUM_FLAGS-1:0];
        end
        set_mask = active;
        set_mask[FLG_FRAMING] = frame_bad;
        s_next.flags = (s_reg.flags & ~(clr_mask & ~active)) | set_mask;
        // Reads after a wake while the link is idle start with the flag register
        if (!s_reg.wake_enable_pin_d && s_reg.s2.wake_enable_pin && s_reg.lk == LK_IDLE)
        begin
            s_next.sel = SEL_FAULT_FLAGS;
        end

        s_next.fault_n = ~|(s_reg.flags & s_reg.mask[NUM_FLAGS-1:0]);

        half = !s_reg.cfg[CFG_HBRIDGE];
        s_next.ctl.outputs_on = s_reg.cfg[CFG_OUTPUT_ENABLE] && s_reg.s2.wake_enable_pin
            && !s_reg.s2.dis;
        s_next.ctl.drive_1 = s_reg.cfg[CFG_DRIVE_SOURCE] ? s_reg.cfg[CFG_VIRTUAL_1]
            : s_reg.s2.in1;
        s_next.ctl.drive_2 = s_reg.cfg[CFG_DRIVE_SOURCE] ? s_reg.cfg[CFG_VIRTUAL_2]
            : s_reg.s2.in2;
        s_next.ctl.limit_active = s_reg.cfg[CFG_ACTIVE_LIMIT] && !half;
        s_next.ctl.limit_code = s_reg.cfg[CFG_LIMIT_HI:CFG_LIMIT_LO];
        // Derate on enabled mode follows the live warning, not the latched flag
        s_next.ctl.limit_half = !s_reg.cfg[CFG_THERMAL_DERATE]
            || s_reg.s2.fault[FLG_THERMAL_WARN];
        s_next.ctl.limit_blanked = s_reg.cfg[CFG_THERMAL_DERATE];
        s_next.ctl.slew_code = s_reg.cfg[CFG_SLEW_HI:CFG_SLEW_LO];
        s_next.ctl.open_load_check = s_reg.cfg[CFG_OPEN_LOAD_CHECK] && !half;
        s_next.ctl.open_load_test = !s_reg.ctl.open_load_check
            && s_reg.cfg[CFG_OPEN_LOAD_CHECK] && !half
            && !s_reg.ctl.outputs_on;
        s_next.ctl.ov_protect = s_reg.s2.fault[FLG_SUPPLY_HIGH] && !half
            && !s_reg.mask[MSK_OV_PROTECT_OFF];
    end

    always_ff @(posedge MCLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            s_reg <= CORE_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign MISO_OUT = s_reg.miso;
    assign MISO_OE_N_OUT = s_reg.miso_oe_n;
    assign FAULT_PIN_N_OUT = s_reg.fault_n;
    assign DRIVE_CTL_OUT = s_reg.ctl;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    property p_latch;
        s_reg.s2.fault[FLG_OVERTEMP] |=> s_reg.flags[FLG_OVERTEMP];
    endproperty
    a_latch: assert property (p_latch)
        else $error("overtemperature flag not latched");

    property p_hold_active;
        s_reg.s2.fault[FLG_SUPPLY_LOW] && s_reg.flags[FLG_SUPPLY_LOW] |=> s_reg.flags[FLG_SUPPLY_LOW];
    endproperty
    a_hold_active: assert property (p_hold_active)
        else $error("active fault flag was cleared");

    property p_dis_clear;
        $fell(s_reg.s2.dis) && s_reg.s2.fault == 11'h000 && s_reg.lk != LK_END
            |=> s_reg.flags == 12'h000;
    endproperty
    a_dis_clear: assert property (p_dis_clear)
        else $error("disable falling edge did not clear flags");

    property p_wake_enable_pin_clear;
        $rose(s_reg.s2.wake_enable_pin) && s_reg.s2.fault == 11'h000 && s_reg.lk != LK_END
            |=> s_reg.flags == 12'h000;
    endproperty
    a_wake_enable_pin_clear: assert property (p_wake_enable_pin_clear)
        else $error("enable rising edge did not clear flags");

    property p_count_error;
        s_reg.lk == LK_END && s_reg.cnt != 4'h0 |=> s_reg.flags[FLG_FRAMING];
    endproperty
    a_count_error: assert property (p_count_error)
        else $error("bad clock count not flagged");

    property p_id_write;
        s_reg.lk == LK_END && s_reg.any && s_reg.cnt == 4'h0 && s_reg.shift[15]
            && s_reg.shift[14:13] == SEL_IDENTITY |=> s_reg.flags[FLG_FRAMING];
    endproperty
    a_id_write: assert property (p_id_write)
        else $error("identity write not flagged");

    property p_discard;
        s_reg.lk == LK_END && frame_bad
            |=> $stable(s_reg.mask) && $stable(s_reg.cfg) && $stable(s_reg.sel);
    endproperty
    a_discard: assert property (p_discard)
        else $error("bad frame updated a register");

    property p_fault_pin;
        (s_reg.flags & s_reg.mask[11:0]) != 12'h000 ##1 1'b1 |-> !FAULT_PIN_N_OUT;
    endproperty
    a_fault_pin: assert property (p_fault_pin)
        else $error("fault pin not asserted for masked fault");

    property p_flag_echo;
        s_reg.lk == LK_IDLE && s_reg.cs_n_d && !s_reg.s2.cs_n
            && s_reg.sel == SEL_FAULT_FLAGS |=> s_reg.shift[15:12] == 4'h2;
    endproperty
    a_flag_echo: assert property (p_flag_echo)
        else $error("flag readback header wrong");

    property p_load_test;
        $rose(DRIVE_CTL_OUT.open_load_check) && !$past(DRIVE_CTL_OUT.outputs_on)
            |-> DRIVE_CTL_OUT.open_load_test;
    endproperty
    a_load_test: assert property (p_load_test)
        else $error("open-load test not started");

endmodule : hbridge_spi_fault_registers

// [verification/hbridge_host_model.sv]
// Host serial master model driving the register bank's serial port
module hbridge_host_model
(
    // Link to the device
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Sends bits n-1..0 MSB first; the clock stands low between frames
    task automatic xfer(input logic [31:0] word, input int n, output logic [31:0] rx);
        rx = 32'h0;
        // Offset keeps link edges away from the system clock edges
        #13 cs_n_out = 1'b0;
        #400;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk_out = 1'b1;
            mosi_out = word[i];
            // Output data is valid at the falling edge, so it is taken just before it
            #200 rx = {rx[30:0], miso_in};
            sclk_out = 1'b0;
            #200;
        end
        cs_n_out = 1'b1;
        // Released data line must not keep showing the last bit
        mosi_out = ~mosi_out;
        #600;
    endtask : xfer
endmodule : hbridge_host_model

// [verification/hbridge_spi_fault_registers_tb.sv]
// Self-checking bench for the H-bridge serial register bank
module hbridge_spi_fault_registers_tb;
    import hbridge_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk, nrst, sclk, cs_n, mosi, miso, miso_oe_n, miso_line;
    logic dis, wake_enable_pin, in1, in2, fault_pin_n;
    logic [10:0] fault;
    drive_ctl_t ctl;
    logic [12:0] mask_m, cfg_m;
    logic [11:0] flags_m;
    logic [31:0] rx;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int bad[3] = '{0, 15, 17};

    // Identity value is arbitrary
    hbridge_spi_fault_registers #(.DEVICE_ID_BIT(1'b0), .REVISION(4'hA))
        hbridge_spi_fault_registers_inst (
        .MCLK_IN(mclk), .NRST_IN(nrst), .SCLK_IN(sclk), .CS_N_IN(cs_n), .MOSI_IN(mosi),
        .MISO_OUT(miso), .MISO_OE_N_OUT(miso_oe_n), .OUTPUT_DISABLE_PIN_IN(dis),
        .WAKE_ENABLE_PIN_IN(wake_enable_pin), .DRIVE_1_PIN_IN(in1), .DRIVE_2_PIN_IN(in2),
        .FAULT_ACTIVE_IN(fault), .FAULT_PIN_N_OUT(fault_pin_n), .DRIVE_CTL_OUT(ctl));

    hbridge_host_model hbridge_host_model_inst (
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso_line));

    // Undriven data line shows the inverse of the last driven bit, never a stale copy
    assign miso_line = miso_oe_n ? ~miso : miso;

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            errors = errors + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] cmd(input logic wr, input logic [1:0] sel,
                                        input logic [12:0] d);
        return {wr, sel, d};
    endfunction : cmd

    function automatic logic [15:0] view(input logic [1:0] sel);
        case (sel)
            2'h0: return 16'h000A;
            2'h1: return {4'h2, flags_m};
            2'h2: return {3'h2, mask_m};
            default: return {3'h3, cfg_m};
        endcase
    endfunction : view

    // Steady controls expected from a configuration and live detector levels
    function automatic drive_ctl_t exp_ctl(input logic [12:0] c, input logic [10:0] f);
        drive_ctl_t e;
        e = '0;
        e.outputs_on = c[4] && wake_enable_pin && !dis;
        e.drive_1 = c[2] ? c[0] : in1;
        e.drive_2 = c[2] ? c[1] : in2;
        e.limit_active = c[10] && c[3];
        e.limit_code = c[9:8];
        e.limit_half = !c[11] || f[1];
        e.limit_blanked = c[11];
        e.slew_code = c[7:5];
        e.open_load_check = c[12] && c[3];
        e.ov_protect = f[8] && c[3] && !mask_m[12];
        return e;
    endfunction : exp_ctl

    // The one-cycle open-load test pulse is left out here
    task automatic check_ctl(input string name);
        drive_ctl_t seen;
        seen = ctl;
        seen.open_load_test = 1'b0;
        check(name, 16'(seen), 16'(exp_ctl(cfg_m, fault)));
    endtask : check_ctl

    task automatic frame(input logic [31:0] w, input int n);
        @(negedge mclk);
        hbridge_host_model_inst.xfer(w, n, rx);
    endtask : frame

    task automatic write(input logic [1:0] sel, input logic [12:0] d);
        frame({16'h0, cmd(1'b1, sel, d)}, 16);
    endtask : write

    // Content bits of a read are random and must be ignored
    task automatic read_check(input string name, input logic [1:0] sel);
        frame({16'h0, cmd(1'b0, sel, 13'($urandom))}, 16);
        frame(32'h0, 16);
        check(name, rx[15:0], view(sel));
        check("oe", 16'(miso_oe_n), 16'h1);
    endtask : read_check

    // Pulse of 25 cycles exceeds the 1 us the host must give
    task automatic pulse(input logic use_dis);
        @(negedge mclk);
        dis = use_dis;
        wake_enable_pin = use_dis;
        repeat (25) @(negedge mclk);
        dis = 1'b0;
        wake_enable_pin = 1'b1;
        repeat (4) @(negedge mclk);
    endtask : pulse

    initial
    begin
        void'($urandom(1257));
        nrst = 1'b0;
        dis = 1'b0;
        wake_enable_pin = 1'b1;
        in1 = 1'b0;
        in2 = 1'b0;
        fault = 11'h000;
        mask_m = 13'h06F1;
        cfg_m = 13'h0D98;
        flags_m = 12'h000;
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        repeat (8) @(negedge mclk);
        frame(32'h0, 16);
        check("first", rx[15:0], view(2'h1));
        for (int s = 0; s < 4; s++)
            read_check("reset", 2'(s));
        check("ctl", 16'({ctl.limit_code, ctl.slew_code}), 16'h000C);
        check_ctl("ctl reset");
        for (int k = 0; k < 4; k++)
        begin
            mask_m = 13'($urandom);
            // Standby first, then open-load check on, so the test pulse is exercised
            cfg_m = (k == 0) ? 13'h0008 : (k == 1) ? 13'h1008 : 13'($urandom);
            in1 = 1'($urandom);
            in2 = 1'($urandom);
            write(2'h2, mask_m);
            write(2'h3, cfg_m);
            read_check("mask", 2'h2);
            read_check("cfg", 2'h3);
            check("lim", 16'({ctl.limit_code, ctl.slew_code}), 16'(cfg_m[9:5]));
            check("on", 16'(ctl.outputs_on), 16'(cfg_m[4]));
            check_ctl("ctl cfg");
        end
        for (int i = 0; i < 11; i++)
        begin
            @(negedge mclk);
            fault[i] = 1'b1;
            flags_m[i] = 1'b1;
            repeat (6) @(negedge mclk);
            check("pin", 16'(fault_pin_n), 16'(!mask_m[i]));
            check_ctl("ctl fault");
            if (i == 8)
                check("ovp", 16'(ctl.ov_protect), 16'(cfg_m[3] & ~mask_m[12]));
            write(2'h1, 13'(1) << i);
            read_check("active", 2'h1);
            @(negedge mclk);
            fault[i] = 1'b0;
            write(2'h1, 13'h0000);
            read_check("held", 2'h1);
            if (i % 3 == 0)
                write(2'h1, 13'h1000 | (13'(1) << i));
            else
                pulse(i % 3 == 1);
            flags_m[i] = 1'b0;
            read_check("cleared", 2'h1);
            check("pin off", 16'(fault_pin_n), 16'h0001);
        end
        foreach (bad[j])
        begin
            frame({15'h0, 1'b0, cmd(1'b1, 2'h2, ~mask_m)}, bad[j]);
            flags_m[11] = 1'b1;
            read_check("frame", 2'h1);
            read_check("discard", 2'h2);
            write(2'h1, 13'h0800);
            flags_m[11] = 1'b0;
        end
        write(2'h0, 13'($urandom));
        flags_m[11] = 1'b1;
        read_check("id write", 2'h1);
        read_check("id", 2'h0);
        write(2'h1, 13'h0800);
        flags_m[11] = 1'b0;
        frame({cmd(1'b1, 2'h2, 13'h0123), cmd(1'b1, 2'h2, 13'h0456)}, 32);
        check("chain lead", rx[31:16], view(2'h1));
        check("chain pass", rx[15:0], cmd(1'b1, 2'h2, 13'h0123));
        mask_m = 13'h0456;
        read_check("chain", 2'h2);
        give_verdict();
    end
endmodule : hbridge_spi_fault_registers_tb
